// [core/brs_regs.v]
// Copy engine parser register bank: mode, condition codes, mailboxes and ring pointers.
// Assumes register and parser strobes come from logic on ref_clk; no synchronisers needed.
`timescale 1ns/10ps
`default_nettype none
`include "brs_map.vh"
module brs_regs (
    // Clock, reset, enable
    input wire ref_clk,
    input wire resetn,
    input wire ce,
    // Register port
    input wire [17:0] reg_addr,
    input wire reg_wr,
    input wire reg_rd,
    input wire [31:0] reg_wdata,
    output reg [31:0] reg_rdata,
    output reg reg_rvalid,
    // Streamer semaphore writes
    input wire render_sem_wr,
    input wire [31:0] render_sem_data,
    input wire video_sem_wr,
    input wire [31:0] video_sem_data,
    // Parser side
    input wire fetch_ack,
    input wire wfe_cmd,
    input wire [2:0] wfe_sel,
    input wire flush_done,
    output reg fetch_req,
    output reg [31:0] fetch_addr,
    output reg fetch_global_xlat,
    output reg ring_in_arbitration,
    output reg wfe_dropped,
    output reg flush_req,
    output reg mem_sync_en,
    output reg [15:0] arb_mode_bits,
    // Mailbox contents for the copy streamer
    output wire [31:0] render_sem_value,
    output wire [31:0] video_sem_value
);
    // ==========================================================
    // Helpers
    // Masked update: upper half enables each bit of the lower half
    function [15:0] masked_upd;
        input [15:0] old;
        input [31:0] wd;
        begin
            masked_upd = (old & ~wd[31:16]) | (wd[15:0] & wd[31:16]);
        end
    endfunction

    // Pick one condition bit; selects past the implemented ones read as zero
    function cond_pick;
        input [4:0] cc;
        input [2:0] sel;
        begin
            cond_pick = (sel < `BRS_COND_COUNT) ? cc[sel] : 1'b0;
        end
    endfunction

    // ==========================================================
    // State
    reg [15:0] pmc_reg, pmc_next;
    reg [4:0] excc_reg, excc_next;
    reg [15:0] arb_reg, arb_next;
    reg [17:0] tail_reg, tail_next;
    reg [18:0] head_reg, head_next;
    reg [10:0] wrap_reg, wrap_next;
    reg [19:0] start_reg, start_next;
    reg [8:0] len_reg, len_next;
    reg en_reg, en_next;
    reg wait_reg, wait_next;
    reg [2:0] wsel_reg, wsel_next;
    reg drop_next;
    reg fetch_next;
    reg [31:0] rd_next;

    wire wr_pmc = reg_wr && (reg_addr == `BRS_PMC_OFS);
    wire wr_excc = reg_wr && (reg_addr == `BRS_EXCC_OFS);
    wire wr_arb = reg_wr && (reg_addr == `BRS_ARB_OFS);
    wire wr_tail = reg_wr && (reg_addr == `BRS_TAIL_OFS);
    wire wr_head = reg_wr && (reg_addr == `BRS_HEAD_OFS);
    wire wr_start = reg_wr && (reg_addr == `BRS_START_OFS);
    wire wr_ctl = reg_wr && (reg_addr == `BRS_CTL_OFS);
    wire wr_rsem = reg_wr && (reg_addr == `BRS_RSEM_OFS);
    wire wr_vsem = reg_wr && (reg_addr == `BRS_VSEM_OFS);

    // Ring is empty once the head reaches the tail quadword
    wire ring_empty = (head_reg[18:1] == tail_reg);
    wire can_fetch = en_reg && !wait_reg && !ring_empty;
    wire advance = fetch_ack && fetch_req && can_fetch;
    wire [19:0] head_inc = {1'b0, head_reg} + 20'h00001;
    wire [9:0] len_pages = {1'b0, len_reg} + 10'h001;
    wire head_wraps = (head_inc == {len_pages, 10'h000});
    // Only the five implemented condition bits are kept; the rest is cut on purpose
    wire [15:0] excc_upd = masked_upd({11'h000, excc_reg}, reg_wdata);

    // ==========================================================
    // Mode and condition registers
    // The flush request stays set if software sets it in the cycle it completes
    always @* begin
        pmc_next = pmc_reg;
        if (flush_done) begin
            pmc_next[`BRS_PMC_FLUSH_BIT] = 1'b0;
        end
        if (wr_pmc) begin
            pmc_next = masked_upd(pmc_next, reg_wdata);
        end
        excc_next = excc_reg;
        if (wr_excc) begin
            excc_next = excc_upd[4:0];
        end
        arb_next = wr_arb ? masked_upd(arb_reg, reg_wdata) : arb_reg;
    end

    // ==========================================================
    // Ring pointers
    // Head writes while enabled are taken as-is; software must avoid them
    always @* begin
        tail_next = wr_tail ? reg_wdata[20:3] : tail_reg;
        start_next = wr_start ? reg_wdata[31:12] : start_reg;
        len_next = wr_ctl ? reg_wdata[`BRS_CTL_LEN_HI:`BRS_CTL_LEN_LO] : len_reg;
        en_next = wr_ctl ? reg_wdata[`BRS_CTL_EN_BIT] : en_reg;
        head_next = head_reg;
        wrap_next = wrap_reg;
        if (wr_head) begin
            head_next = reg_wdata[20:2];
            wrap_next = reg_wdata[31:21];
        end else if (advance) begin
            if (head_wraps) begin
                head_next = 19'h00000;
                wrap_next = wrap_reg + 11'h001;
            end else begin
                head_next = head_inc[18:0];
            end
        end
    end

    // ==========================================================
    // Wait-for-event
    // A new wait that lands with a software clear still takes effect
    always @* begin
        wait_next = wait_reg;
        wsel_next = wsel_reg;
        drop_next = 1'b0;
        if (wait_reg && !cond_pick(excc_reg, wsel_reg)) begin
            wait_next = 1'b0;
        end
        if (wr_ctl && reg_wdata[`BRS_CTL_WAIT_BIT]) begin
            wait_next = 1'b0;
        end
        if (wfe_cmd && en_reg && !wait_reg) begin
            if (cond_pick(excc_reg, wfe_sel)) begin
                wait_next = 1'b1;
                wsel_next = wfe_sel;
            end else begin
                drop_next = 1'b1;
            end
        end
    end

    // ==========================================================
    // Read mux and fetch request
    // Unmapped offsets read zero; the enable half of masked registers reads zero
    always @* begin
        case (reg_addr)
            `BRS_PMC_OFS: rd_next = {16'h0000, pmc_reg};
            `BRS_EXCC_OFS: rd_next = {27'h0000000, excc_reg};
            `BRS_ARB_OFS: rd_next = {16'h0000, arb_reg};
            `BRS_TAIL_OFS: rd_next = {11'h000, tail_reg, 3'h0};
            `BRS_HEAD_OFS: rd_next = {wrap_reg, head_reg, 2'h0};
            `BRS_START_OFS: rd_next = {start_reg, 12'h000};
            `BRS_CTL_OFS: rd_next = {11'h000, len_reg, wait_reg, 10'h000, en_reg};
            `BRS_RSEM_OFS: rd_next = render_sem_value;
            `BRS_VSEM_OFS: rd_next = video_sem_value;
            default: rd_next = `BRS_RST_32;
        endcase
        fetch_next = en_next && !wait_next && (head_next[18:1] != tail_next);
    end

    // ==========================================================
    // Registers and outputs
    // Parser-side outputs follow the next state so a fetch handshake sees no extra lag
    always @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            pmc_reg <= `BRS_RST_16;
            excc_reg <= 5'h00;
            arb_reg <= `BRS_RST_16;
            tail_reg <= 18'h00000;
            head_reg <= 19'h00000;
            wrap_reg <= 11'h000;
            start_reg <= 20'h00000;
            len_reg <= 9'h000;
            en_reg <= 1'b0;
            wait_reg <= 1'b0;
            wsel_reg <= 3'h0;
            reg_rdata <= `BRS_RST_32;
            reg_rvalid <= 1'b0;
            fetch_req <= 1'b0;
            fetch_addr <= `BRS_RST_32;
            fetch_global_xlat <= 1'b1;
            ring_in_arbitration <= 1'b0;
            wfe_dropped <= 1'b0;
            flush_req <= 1'b0;
            mem_sync_en <= 1'b0;
            arb_mode_bits <= `BRS_RST_16;
        end else if (ce) begin
            pmc_reg <= pmc_next;
            excc_reg <= excc_next;
            arb_reg <= arb_next;
            tail_reg <= tail_next;
            head_reg <= head_next;
            wrap_reg <= wrap_next;
            start_reg <= start_next;
            len_reg <= len_next;
            en_reg <= en_next;
            wait_reg <= wait_next;
            wsel_reg <= wsel_next;
            reg_rdata <= reg_rd ? rd_next : `BRS_RST_32;
            reg_rvalid <= reg_rd;
            fetch_req <= fetch_next;
            fetch_addr <= {start_next, 12'h000} + {11'h000, head_next, 2'h0};
            fetch_global_xlat <= 1'b1;
            ring_in_arbitration <= en_next && !wait_next;
            wfe_dropped <= drop_next;
            flush_req <= pmc_next[`BRS_PMC_FLUSH_BIT];
            mem_sync_en <= pmc_next[`BRS_PMC_MSYNC_BIT];
            arb_mode_bits <= arb_next;
        end
    end

    // ==========================================================
    // Semaphore mailboxes
    brs_mailbox u_mailbox (
        .ref_clk(ref_clk),
        .resetn(resetn),
        .ce(ce),
        .sw_wr(wr_rsem || wr_vsem),
        .sw_sel(wr_vsem),
        .sw_data(reg_wdata),
        .render_wr(render_sem_wr),
        .render_data(render_sem_data),
        .video_wr(video_sem_wr),
        .video_data(video_sem_data),
        .render_word(render_sem_value),
        .video_word(video_sem_value)
    );
endmodule
`default_nettype wire

// [inc/brs_map.vh]
// Register map, field positions and reset values of the copy engine ring and sync register bank.
// Assumes a 32-bit register port with 18-bit byte addresses and one engine clock.
// Functional notes
// - Software requests a sync flush; hardware clears the request bit when done.
// - Condition-code bits 31:16 are per-bit write enables for bits 15:0; the code keeps only bits 4:0, so enables 31:21 have no effect.
// - Condition-code enable half always reads back as zero.
// - Wait-for-event leaves arbitration if condition is 1, else command is dropped.
// - A waiting ring returns to arbitration once its selected condition reads 0.
// - Render streamer writes the 32-bit render mailbox; copy streamer reads it.
// - Video streamer writes the 32-bit video mailbox; copy streamer reads it.
// - Arbiter mode bits 31:16 gate updates of matching bits 15:0.
// - Eleven-bit wrap count in 31:21 increments on each head wrap, rolls over.
// - Head offset 20:2 advances while executing until it reaches tail quadword.
// - Ring addresses always translate through the global translation table.
// - Ring enable bit 0 starts or stops the ring at any time.
// - Waiting flag bit 11 set during a wait; write 1 ends wait, 0 ignored.
`ifndef BRS_MAP_VH
`define BRS_MAP_VH
// ==========================================================
// Register offsets
`define BRS_EXCC_OFS 18'h22028
`define BRS_TAIL_OFS 18'h22030
`define BRS_HEAD_OFS 18'h22034
`define BRS_START_OFS 18'h22038
`define BRS_CTL_OFS 18'h2203c
`define BRS_RSEM_OFS 18'h22040
`define BRS_VSEM_OFS 18'h22044
`define BRS_ARB_OFS 18'h220a0
`define BRS_PMC_OFS 18'h220c0
// ==========================================================
// Field positions
`define BRS_PMC_FLUSH_BIT 5
`define BRS_PMC_MSYNC_BIT 6
`define BRS_CTL_EN_BIT 0
`define BRS_CTL_WAIT_BIT 11
`define BRS_CTL_LEN_LO 12
`define BRS_CTL_LEN_HI 20
`define BRS_COND_COUNT 5
// ==========================================================
// Reset values
`define BRS_RST_16 16'h0000
`define BRS_RST_32 32'h0000_0000
`endif

// [core/brs_mailbox.v]
// Two-word semaphore mailbox storage shared by software and the streamers.
// Assumes all writers are on the engine clock; streamer writes win collisions.
`timescale 1ns/10ps
`default_nettype none
`include "brs_map.vh"
module brs_mailbox (
    // Clock, reset, enable
    input wire ref_clk,
    input wire resetn,
    input wire ce,
    // Software write port
    input wire sw_wr,
    input wire sw_sel,
    input wire [31:0] sw_data,
    // Streamer write ports
    input wire render_wr,
    input wire [31:0] render_data,
    input wire video_wr,
    input wire [31:0] video_data,
    // Stored words
    output reg [31:0] render_word,
    output reg [31:0] video_word
);
    // ==========================================================
    // Storage
    // A streamer update is the live semaphore, so it overrides a racing software write
    always @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            render_word <= `BRS_RST_32;
            video_word <= `BRS_RST_32;
        end else if (ce) begin
            if (render_wr) begin
                render_word <= render_data;
            end else if (sw_wr && !sw_sel) begin
                render_word <= sw_data;
            end
            if (video_wr) begin
                video_word <= video_data;
            end else if (sw_wr && sw_sel) begin
                video_word <= sw_data;
            end
        end
    end
endmodule
`default_nettype wire

// [testbench/brs_regs_properties.sv]
// Port-level assertions for the copy engine ring and sync register bank.
// Assumes it is bound to brs_regs; one clock, asynchronous active-low reset.
`timescale 1ns/10ps
`default_nettype none
`include "brs_map.vh"
module brs_props (
    // Clock, reset, enable
    input wire logic ref_clk,
    input wire logic resetn,
    input wire logic ce,
    // Register port
    input wire logic [17:0] reg_addr,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [31:0] reg_wdata,
    input wire logic [31:0] reg_rdata,
    input wire logic reg_rvalid,
    // Parser side
    input wire logic fetch_ack,
    input wire logic wfe_cmd,
    input wire logic flush_done,
    input wire logic fetch_req,
    input wire logic [31:0] fetch_addr,
    input wire logic fetch_global_xlat,
    input wire logic ring_in_arbitration,
    input wire logic wfe_dropped,
    input wire logic flush_req,
    input wire logic [15:0] arb_mode_bits
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!resetn);
    // ==========================================================
    // Register port and parser relations
    xlat_global_a:
        assert property (fetch_global_xlat) else $error("per-process translation used");
    excc_upper_a:
        assert property (ce && reg_rd && reg_addr == `BRS_EXCC_OFS
            |=> reg_rvalid && reg_rdata[31:16] == 16'h0000) else $error("enable half not zero");
    arb_mask_a:
        assert property (ce && reg_wr && reg_addr == `BRS_ARB_OFS |=> arb_mode_bits ==
            (($past(arb_mode_bits) & ~$past(reg_wdata[31:16]))
            | ($past(reg_wdata[15:0]) & $past(reg_wdata[31:16]))))
            else $error("arbiter mode mask ignored");
    // Write excluded: software may set the request again in the done cycle
    flush_clear_a:
        assert property (ce && flush_done && !reg_wr |-> ##[1:2] !flush_req)
            else $error("flush request not cleared");
    wfe_outcome_a:
        assert property (ce && wfe_cmd && ring_in_arbitration && !reg_wr
            |=> ring_in_arbitration == wfe_dropped) else $error("wait outcome wrong");
    drop_cause_a:
        assert property (wfe_dropped |-> $past(wfe_cmd)) else $error("drop without command");
    fetch_gate_a:
        assert property (fetch_req |-> ring_in_arbitration) else $error("fetch while parked");
    // Page end excluded: a wrap returns to the ring start instead
    fetch_step_a:
        assert property (ce && fetch_ack && fetch_req && !reg_wr && fetch_addr[11:0] != 12'hffc
            |=> fetch_addr == $past(fetch_addr) + 32'h4) else $error("head step wrong");
endmodule
`default_nettype wire

// [testbench/brs_testbench.sv]
// Self-checking bench for brs_regs, one task per scenario.
// Assumes brs_map.vh on the include path and the checker compiled first.
`timescale 1ns/10ps
`default_nettype none
`include "brs_map.vh"
module testbench;
    logic ref_clk = 1'b0;
    logic resetn = 1'b0;
    logic ce = 1'b1;
    logic [17:0] reg_addr = 18'h00000;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [31:0] reg_wdata = 32'h0;
    logic render_sem_wr = 1'b0;
    logic video_sem_wr = 1'b0;
    logic [31:0] sem_data = 32'h0;
    logic fetch_ack = 1'b0;
    logic wfe_cmd = 1'b0;
    logic [2:0] wfe_sel = 3'h0;
    logic flush_done = 1'b0;
    wire [31:0] reg_rdata, fetch_addr, render_sem_value, video_sem_value;
    wire reg_rvalid, fetch_req, fetch_global_xlat, ring_in_arbitration;
    wire wfe_dropped, flush_req, mem_sync_en;
    wire [15:0] arb_mode_bits;
    int error_cnt = 0;
    int num_checks = 0;
    // 125 MHz engine clock
    always #4 ref_clk = ~ref_clk;
    brs_regs i_dut (.ref_clk(ref_clk), .resetn(resetn), .ce(ce), .reg_addr(reg_addr),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
        .reg_rvalid(reg_rvalid), .render_sem_wr(render_sem_wr), .render_sem_data(sem_data),
        .video_sem_wr(video_sem_wr), .video_sem_data(sem_data), .fetch_ack(fetch_ack),
        .wfe_cmd(wfe_cmd), .wfe_sel(wfe_sel), .flush_done(flush_done), .fetch_req(fetch_req),
        .fetch_addr(fetch_addr), .fetch_global_xlat(fetch_global_xlat),
        .ring_in_arbitration(ring_in_arbitration), .wfe_dropped(wfe_dropped),
        .flush_req(flush_req), .mem_sync_en(mem_sync_en), .arb_mode_bits(arb_mode_bits),
        .render_sem_value(render_sem_value), .video_sem_value(video_sem_value));
    // ==========================================================
    // Shared tasks
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // One write strobe, launched and dropped on falling edges
    task automatic wr(input logic [17:0] a, input logic [31:0] d);
        @(negedge ref_clk);
        reg_addr = a;
        reg_wdata = d;
        reg_wr = 1'b1;
        @(negedge ref_clk);
        reg_wr = 1'b0;
    endtask
    // Read data is registered, so it is settled one falling edge later
    task automatic rd(input logic [17:0] a, input logic [31:0] exp);
        @(negedge ref_clk);
        reg_addr = a;
        reg_rd = 1'b1;
        @(negedge ref_clk);
        reg_rd = 1'b0;
        chk(reg_rvalid, 1'b1);
        chk(reg_rdata, exp);
    endtask
    // Acknowledge n dwords, expecting consecutive addresses from a
    task automatic ack_n(input int n, input logic [31:0] a);
        for (int i = 0; i < n; i++) begin
            for (int k = 0; k < 4 && fetch_req !== 1'b1; k++) @(negedge ref_clk);
            chk(fetch_req, 1'b1);
            chk(fetch_addr, a + 32'h4 * i);
            fetch_ack = 1'b1;
            @(negedge ref_clk);
        end
        fetch_ack = 1'b0;
        // Let one edge pass so a following call never re-raises ack in this step
        @(negedge ref_clk);
    endtask
    task automatic wfe(input logic [2:0] s);
        @(negedge ref_clk);
        wfe_cmd = 1'b1;
        wfe_sel = s;
        @(negedge ref_clk);
        wfe_cmd = 1'b0;
    endtask
    // ==========================================================
    // Scenarios
    task automatic t_reset();
        logic [17:0] ofs[10] = '{`BRS_EXCC_OFS, `BRS_TAIL_OFS, `BRS_HEAD_OFS, `BRS_START_OFS,
            `BRS_CTL_OFS, `BRS_RSEM_OFS, `BRS_VSEM_OFS, `BRS_ARB_OFS, `BRS_PMC_OFS, 18'h22100};
        foreach (ofs[i]) rd(ofs[i], 32'h0);
        chk(fetch_global_xlat, 1'b1);
        $display("%0t reset values done", $time);
    endtask
    task automatic t_masks();
        wr(`BRS_EXCC_OFS, 32'h0003_ffff);
        rd(`BRS_EXCC_OFS, 32'h0000_0003);
        wr(`BRS_EXCC_OFS, 32'h0000_001c);
        rd(`BRS_EXCC_OFS, 32'h0000_0003);
        wr(`BRS_ARB_OFS, 32'h00f0_ffff);
        rd(`BRS_ARB_OFS, 32'h0000_00f0);
        chk(arb_mode_bits, 16'h00f0);
        wr(`BRS_EXCC_OFS, 32'h0003_0000);
        $display("%0t masked writes done", $time);
    endtask
    // A low clock enable must freeze the register state
    task automatic t_freeze();
        @(negedge ref_clk);
        ce = 1'b0;
        wr(`BRS_ARB_OFS, 32'h000f_000f);
        chk(arb_mode_bits, 16'h00f0);
        @(negedge ref_clk);
        ce = 1'b1;
        rd(`BRS_ARB_OFS, 32'h0000_00f0);
        $display("%0t clock enable freeze done", $time);
    endtask
    task automatic t_mbox();
        wr(`BRS_RSEM_OFS, 32'h1234_5678);
        rd(`BRS_RSEM_OFS, 32'h1234_5678);
        // A software write racing the streamer write must lose
        @(negedge ref_clk);
        sem_data = 32'h0bad_cafe;
        video_sem_wr = 1'b1;
        render_sem_wr = 1'b1;
        reg_addr = `BRS_RSEM_OFS;
        reg_wdata = 32'h5555_5555;
        reg_wr = 1'b1;
        @(negedge ref_clk);
        video_sem_wr = 1'b0;
        render_sem_wr = 1'b0;
        reg_wr = 1'b0;
        chk(render_sem_value, 32'h0bad_cafe);
        chk(video_sem_value, 32'h0bad_cafe);
        rd(`BRS_VSEM_OFS, 32'h0bad_cafe);
        $display("%0t mailboxes done", $time);
    endtask
    task automatic t_flush();
        wr(`BRS_PMC_OFS, 32'h0060_0060);
        @(negedge ref_clk);
        chk(flush_req, 1'b1);
        chk(mem_sync_en, 1'b1);
        flush_done = 1'b1;
        @(negedge ref_clk);
        flush_done = 1'b0;
        @(negedge ref_clk);
        chk(flush_req, 1'b0);
        rd(`BRS_PMC_OFS, 32'h0000_0040);
        $display("%0t flush done", $time);
    endtask
    task automatic t_ring();
        // Ring pages are taken as uncached main memory behind fetch_addr
        wr(`BRS_START_OFS, 32'h0000_1000);
        wr(`BRS_TAIL_OFS, 32'h0000_0010);
        wr(`BRS_CTL_OFS, 32'h0000_0001);
        ack_n(4, 32'h0000_1000);
        chk(fetch_req, 1'b0);
        rd(`BRS_HEAD_OFS, 32'h0000_0010);
        wr(`BRS_TAIL_OFS, 32'h0000_0018);
        ack_n(2, 32'h0000_1010);
        // Head is only rewritten with the ring stopped
        wr(`BRS_CTL_OFS, 32'h0000_0000);
        wr(`BRS_HEAD_OFS, 32'h0000_0ff8);
        wr(`BRS_TAIL_OFS, 32'h0000_0008);
        wr(`BRS_CTL_OFS, 32'h0000_0001);
        ack_n(2, 32'h0000_1ff8);
        ack_n(2, 32'h0000_1000);
        rd(`BRS_HEAD_OFS, 32'h0020_0008);
        $display("%0t ring walk done", $time);
    endtask
    task automatic t_wfe();
        wr(`BRS_EXCC_OFS, 32'h0004_0004);
        wfe(3'h2);
        chk(ring_in_arbitration, 1'b0);
        rd(`BRS_CTL_OFS, 32'h0000_0801);
        wr(`BRS_EXCC_OFS, 32'h0004_0000);
        repeat (2) @(negedge ref_clk);
        chk(ring_in_arbitration, 1'b1);
        wfe(3'h3);
        chk(wfe_dropped, 1'b1);
        wr(`BRS_EXCC_OFS, 32'h0001_0001);
        wfe(3'h0);
        wr(`BRS_CTL_OFS, 32'h0000_0001);
        @(negedge ref_clk);
        chk(ring_in_arbitration, 1'b0);
        wr(`BRS_CTL_OFS, 32'h0000_0801);
        @(negedge ref_clk);
        chk(ring_in_arbitration, 1'b1);
        // Selects past the implemented conditions read as zero, so the command drops
        wfe(3'h5);
        chk(wfe_dropped, 1'b1);
        $display("%0t wait for event done", $time);
    endtask
    // ==========================================================
    // Verdict, main sequence and watchdog
    task automatic finish_test();
        $display("%0d checks, %0d mismatches", num_checks, error_cnt);
        if (error_cnt == 0 && num_checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    initial begin
        repeat (8) @(negedge ref_clk);
        resetn = 1'b1;
        t_reset();
        t_masks();
        t_freeze();
        t_mbox();
        t_flush();
        t_ring();
        t_wfe();
        finish_test();
    end
    // Whole run is about 120 cycles; this 25000-cycle limit is far beyond it
    initial begin
        #200000;
        error_cnt++;
        finish_test();
    end
endmodule
bind brs_regs brs_props i_props (.ref_clk(ref_clk), .resetn(resetn), .ce(ce),
    .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata),
    .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid), .fetch_ack(fetch_ack), .wfe_cmd(wfe_cmd),
    .flush_done(flush_done), .fetch_req(fetch_req), .fetch_addr(fetch_addr),
    .fetch_global_xlat(fetch_global_xlat), .ring_in_arbitration(ring_in_arbitration),
    .wfe_dropped(wfe_dropped), .flush_req(flush_req), .arb_mode_bits(arb_mode_bits));
`default_nettype wire
